// >>> gpc_pin_model.sv
`timescale 1ns/1ps

// ==========================================================
// External sources on the counting, gate and direction pins
module gpc_pin_model (
  input  wire logic  sys_clk_i,  // Bench clock
  output logic [1:0] src_pin_o,  // Counting inputs
  output logic [1:0] gate_pin_o, // Gate inputs
  output logic [1:0] dir_pin_o   // Direction inputs
);
  // Counting input stands low between bursts
  initial {src_pin_o, gate_pin_o, dir_pin_o} = 6'h00;
  // Levels held longer than the synchroniser path, one step per edge
  task automatic hold();
    repeat (6) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic set_src(input int k, input logic v);
    src_pin_o[k] = v;
    hold();
  endtask
  // Full pulses give one rising and one falling edge each
  task automatic pulse_src(input int k, input int n);
    repeat (n) begin
      set_src(k, 1'b1);
      set_src(k, 1'b0);
    end
  endtask
  task automatic set_ctl(input bit gate, input int k, input logic v);
    if (gate) gate_pin_o[k] = v;
    else dir_pin_o[k] = v;
    hold();
  endtask
endmodule // gpc_pin_model

// >>> gpc_pkg.sv
package gpc_pkg;

  // ========================================================
  // Counting input selection
  typedef enum logic [1:0] {
    SRC_PIN, SRC_FAST, SRC_SLOW, SRC_OTHER
  } gpc_src_t;

  // ========================================================
  // Gate selection
  typedef enum logic [1:0] {
    GATE_PIN, GATE_OTHER, GATE_ACMP
  } gpc_gate_t;

  typedef enum logic {MODE_EDGE, MODE_PULSE} gpc_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} gpc_state_t;

  // ========================================================
  // Per-counter configuration bits
  typedef struct packed {
    gpc_src_t  src_sel;     // Counting input source
    logic      src_fall;    // Count falling edges
    gpc_gate_t gate_sel;    // Gate source
    logic      gate_inv;    // Invert gate polarity
    gpc_mode_t mode;        // Edge counting or pulse generation
    logic      start_en;    // Wait for a gate edge to start
    logic      retrig_en;   // Later gate edges restart
    logic      continuous;  // Pulse train runs until stopped
    logic      pause_en;    // Gate level pauses counting
    logic      pause_lvl;   // Gate level that holds the count
    logic      latch_en;    // Gate edge latches the count
    logic      dir_ext;     // Direction from pin
    logic      dir_up;      // Software direction
    logic      out_toggle;  // Toggle, not pulse, on terminal count
    logic      out_inv;     // Output polarity
    logic      src_exp_en;  // Drive source export pin
    logic      gate_exp_en; // Drive gate export pin
  } gpc_cfg_t;

  // ========================================================
  // Routing of the first counter's output
  typedef struct packed {
    logic       ai_samp_en;  // To analog sample clock
    logic       ai_start_en; // To analog start trigger
    logic       ai_conv_en;  // To analog conversion clock
    logic [6:0] trig_en;     // To inter-device trigger lines
    logic       out_pin_en;  // To counter output pin
  } gpc_route_t;

endpackage

// >>> gpc_regs.svh
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// ==========================================================
// Clock and timebase rates, in Hz
`define GPC_SYS_CLK_HZ  50000000
`define GPC_FAST_TB_HZ  20000000
`define GPC_SLOW_TB_HZ  100000

// ==========================================================
// Widths and counts
`define GPC_ACC_W       27
`define GPC_NUM_CTR     2
`define GPC_TRIG_LINES  7
`define GPC_PIN_SYNC_W  6

// ==========================================================
// Reset values
`define GPC_OUT_IDLE    1'b0
`define GPC_OE_N_RST    1'b1

`endif

// >>> gpc_sync.sv
`timescale 1ns/1ps

// ==========================================================
// Two-stage synchroniser for pin levels
module gpc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i, // System clock
  input  wire logic         srst_i,    // Sync reset, high
  input  wire logic [W-1:0] async_i,   // Raw pin levels
  output wire logic [W-1:0] sync_o     // Synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // gpc_sync

// >>> gpc_top.sv
`timescale 1ns/1ps
`include "gpc_regs.svh"

// Functional notes
// - Two counters: source, gate, one output, two registers each.
// - Source edge chosen rising or falling; count up or down.
// - Gate edge or level: start, stop, event, count latch.
// - Terminal count on rollover, shown by internal output.
// - Output pulses or toggles on terminal count; polarity selectable.
// - Pulse generation drives output in toggle mode.
// - Start trigger begins finite or continuous train; continuous runs on.
// - Finite train gives programmed pulse count; retrigger restarts it.
// - Edge counting holds while pause gate is at hold level.
// - Continuous train stops while pause gate is at hold level.
// - Analog compare event reaches a counter only as a gate.
// - Gate sampled and output changed on the active source edge.
// - Timebase source: gate change lands within one period.
// - Source may be fast 20 MHz or slow 100 kHz timebase.
// - Source exportable to its pin; pin undriven after reset.
// - Gate exportable to its pin; pin undriven after reset.
// - First counter output routable to second counter gate.
// - First output drives analog clocks, trigger lines, output pin.
// - External direction: down when pin low, up when high.
module gpc_top
  import gpc_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic                 sys_clk_i,     // 50 MHz clock
  input  wire logic                 srst_i,        // Sync reset, high
  input  wire gpc_cfg_t [1:0]       cfg_i,         // Per-counter setup
  input  wire logic [1:0][CW-1:0]   low_ticks_i,   // Preload or low time
  input  wire logic [1:0][CW-1:0]   high_ticks_i,  // High time
  input  wire logic [1:0][CW-1:0]   pulse_cnt_i,   // Finite pulse count
  input  wire logic [1:0]           arm_i,         // Start operation
  input  wire logic [1:0]           disarm_i,      // Stop operation
  input  wire logic [1:0]           src_pin_i,     // Source pins
  input  wire logic [1:0]           gate_pin_i,    // Gate pins
  input  wire logic [1:0]           dir_pin_i,     // Direction pins
  input  wire logic                 acmp_evt_i,    // Analog compare pulse
  input  wire gpc_route_t           route_i,       // Output routing
  output wire logic [1:0][CW-1:0]   count_o,       // Live count
  output wire logic [1:0][CW-1:0]   latch_o,       // Latched count
  output wire logic [1:0]           running_o,     // Counter armed
  output wire logic [1:0]           tc_o,          // Terminal count pulse
  output wire logic [1:0]           gate_evt_o,    // Gate edge event
  output wire logic [1:0]           int_out_o,     // Internal outputs
  output wire logic [1:0]           src_exp_o,     // Source export level
  output wire logic [1:0]           src_exp_oe_n_o,  // Low drives
  output wire logic [1:0]           gate_exp_o,    // Gate export level
  output wire logic [1:0]           gate_exp_oe_n_o, // Low drives
  output logic                      ai_samp_clk_o, // Analog sample clock
  output logic                      ai_start_o,    // Analog start trigger
  output logic                      ai_conv_clk_o, // Analog conv clock
  output logic [`GPC_TRIG_LINES-1:0] trig_line_o,  // Trigger lines
  output logic                      ctr_out_pin_o, // Counter out pin
  output logic                      ctr_out_oe_n_o // Low drives
);

  localparam int AW = `GPC_ACC_W;
  localparam logic [AW-1:0] SYS_HZ  = AW'(`GPC_SYS_CLK_HZ);
  localparam logic [AW-1:0] FAST_HZ = AW'(`GPC_FAST_TB_HZ);
  localparam logic [AW-1:0] SLOW_HZ = AW'(`GPC_SLOW_TB_HZ);

  // ========================================================
  // Helper functions

  // Phase accumulator step: {wrap, next}
  function automatic logic [AW:0] tb_step(input logic [AW-1:0] acc,
                                          input logic [AW-1:0] inc);
    logic [AW-1:0] s;
    s = acc + inc;
    if (s >= SYS_HZ) begin
      tb_step = {1'b1, s - SYS_HZ};
    end else begin
      tb_step = {1'b0, s};
    end
  endfunction

  // A time of N ticks reloads as N-1; zero acts as one
  function automatic logic [CW-1:0] reload(input logic [CW-1:0] v);
    reload = (v == '0) ? '0 : v - CW'(1);
  endfunction

  // ========================================================
  // Pin synchronisers and previous levels
  logic [`GPC_PIN_SYNC_W-1:0] pin_s;
  logic [`GPC_PIN_SYNC_W-1:0] pin_prev_q;

  gpc_sync #(.W(`GPC_PIN_SYNC_W)) u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   ({dir_pin_i, gate_pin_i, src_pin_i}),
    .sync_o    (pin_s)
  );

  // Previous synced levels for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  // ========================================================
  // Internal timebases as one-cycle enables
  logic [AW-1:0] fast_acc_q;
  logic [AW-1:0] slow_acc_q;
  logic          fast_en_q;
  logic          slow_en_q;
  logic [AW:0]   fast_nx;
  logic [AW:0]   slow_nx;

  assign fast_nx = tb_step(fast_acc_q, FAST_HZ);
  assign slow_nx = tb_step(slow_acc_q, SLOW_HZ);

  // Fast rate is not an integer divide of 50 MHz, so its
  // enables average 20 MHz with two-of-five spacing
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fast_acc_q <= '0;
      slow_acc_q <= '0;
      fast_en_q  <= 1'b0;
      slow_en_q  <= 1'b0;
    end else begin
      fast_acc_q <= fast_nx[AW-1:0];
      slow_acc_q <= slow_nx[AW-1:0];
      fast_en_q  <= fast_nx[AW];
      slow_en_q  <= slow_nx[AW];
    end
  end

  // ========================================================
  // Cross-counter nets
  wire [1:0] out_w;
  wire [1:0] out_prev_w;

  // ========================================================
  // Counter channels
  for (genvar k = 0; k < `GPC_NUM_CTR; k++) begin : g_ctr
    localparam int O = 1 - k;

    gpc_cfg_t      c;
    gpc_state_t    st_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] left_q;
    logic [CW-1:0] latch_q;
    logic          phase_q;
    logic          lvl_q;
    logic          out_q;
    logic          out_prev_q;
    logic          gate_smp_q;
    logic          acmp_hold_q;
    logic          tc_q, evt_q, run_q;
    logic          sexp_q, sexp_oe_n_q, gexp_q, gexp_oe_n_q;
    logic          src_lvl, src_prv, tick, gate_raw, gate, gate_edge;
    logic          up, paused, step, tc, ld;

    assign c = cfg_i[k];

    // Source, gate and direction selection
    always_comb begin
      src_lvl = 1'b0;
      src_prv = 1'b0;
      tick    = 1'b0;
      case (c.src_sel)
        SRC_PIN: begin
          src_lvl = pin_s[k];
          src_prv = pin_prev_q[k];
        end
        SRC_OTHER: begin
          src_lvl = out_w[O];
          src_prv = out_prev_w[O];
        end
        SRC_FAST: begin
          src_lvl = fast_en_q;
          tick    = fast_en_q;
        end
        SRC_SLOW: begin
          src_lvl = slow_en_q;
          tick    = slow_en_q;
        end
        default: src_lvl = 1'b0;
      endcase
      if (c.src_sel == SRC_PIN || c.src_sel == SRC_OTHER) begin
        tick = c.src_fall ? (src_prv & ~src_lvl)
                          : (src_lvl & ~src_prv);
      end
      case (c.gate_sel)
        GATE_PIN:   gate_raw = pin_s[2+k];
        GATE_OTHER: gate_raw = out_w[O];
        GATE_ACMP:  gate_raw = acmp_hold_q;
        default:    gate_raw = 1'b0;
      endcase
      gate = gate_raw ^ c.gate_inv;
      up   = c.dir_ext ? pin_s[4+k] : c.dir_up;
    end

    // Gate is seen only at source ticks, so with a free timebase
    // a change near an edge lands on it or the next one
    assign gate_edge = tick & gate & ~gate_smp_q;
    assign paused = c.pause_en & (gate == c.pause_lvl)
                  & (c.mode == MODE_EDGE | c.continuous);
    assign step = (st_q == ST_RUN) & tick & ~paused;
    // Up counts wrap at all ones, down counts and trains at zero
    assign tc = step & ((c.mode == MODE_EDGE && up) ? (cnt_q == '1)
                                                    : (cnt_q == '0));
    assign ld = ~disarm_i[k] & (arm_i[k]
              | (st_q == ST_WAIT & gate_edge)
              | (st_q == ST_RUN & c.mode == MODE_PULSE
                 & c.retrig_en & c.start_en & gate_edge));

    // Gate sample register; compare pulse held until next edge
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        gate_smp_q  <= 1'b0;
        acmp_hold_q <= 1'b0;
      end else begin
        if (tick) begin
          gate_smp_q <= gate;
        end
        if (acmp_evt_i) begin
          acmp_hold_q <= 1'b1;
        end else if (tick) begin
          acmp_hold_q <= 1'b0;
        end
      end
    end

    // Operation sequencer and count register
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        st_q    <= ST_IDLE;
        cnt_q   <= '0;
        left_q  <= '0;
        phase_q <= 1'b0;
      end else if (disarm_i[k]) begin
        st_q <= ST_IDLE;
      end else if (ld) begin
        st_q    <= (arm_i[k] & c.start_en) ? ST_WAIT : ST_RUN;
        cnt_q   <= (c.mode == MODE_PULSE) ? reload(low_ticks_i[k])
                                          : low_ticks_i[k];
        left_q  <= pulse_cnt_i[k];
        phase_q <= 1'b0;
      end else begin
        case (st_q)
          ST_RUN: begin
            if (step && c.mode == MODE_EDGE) begin
              cnt_q <= up ? cnt_q + CW'(1)
                          : cnt_q - CW'(1);
            end else if (step && cnt_q != '0) begin
              cnt_q <= cnt_q - CW'(1);
            end else if (step) begin
              phase_q <= ~phase_q;
              cnt_q   <= phase_q ? reload(low_ticks_i[k])
                                 : reload(high_ticks_i[k]);
              if (phase_q && !c.continuous) begin
                left_q <= left_q - CW'(1);
                if (left_q <= CW'(1)) begin
                  st_q <= c.retrig_en ? ST_WAIT : ST_IDLE;
                end
              end
            end
          end
          default: begin
            st_q <= (st_q == ST_WAIT) ? ST_WAIT : ST_IDLE;
          end
        endcase
      end
    end

    // Output level changes on source edges and returns to idle on a load
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        lvl_q      <= `GPC_OUT_IDLE;
        out_q      <= `GPC_OUT_IDLE;
        out_prev_q <= `GPC_OUT_IDLE;
      end else begin
        if (ld) begin
          lvl_q <= `GPC_OUT_IDLE;
        end else if (tick) begin
          if (c.out_toggle || c.mode == MODE_PULSE) begin
            lvl_q <= lvl_q ^ tc;
          end else begin
            lvl_q <= tc;
          end
        end
        out_q      <= lvl_q ^ c.out_inv;
        out_prev_q <= out_q;
      end
    end

    // Gate latch and status registers
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        latch_q <= '0;
        tc_q    <= 1'b0;
        evt_q   <= 1'b0;
        run_q   <= 1'b0;
      end else begin
        if (gate_edge && c.latch_en && st_q == ST_RUN) begin
          latch_q <= cnt_q;
        end
        tc_q  <= tc;
        evt_q <= gate_edge;
        run_q <= (st_q != ST_IDLE);
      end
    end

    // Export pins stay undriven until enabled
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        sexp_q      <= 1'b0;
        gexp_q      <= 1'b0;
        sexp_oe_n_q <= `GPC_OE_N_RST;
        gexp_oe_n_q <= `GPC_OE_N_RST;
      end else begin
        sexp_q      <= src_lvl;
        gexp_q      <= gate_raw;
        sexp_oe_n_q <= ~c.src_exp_en;
        gexp_oe_n_q <= ~c.gate_exp_en;
      end
    end

    // Channel outputs, one set per counter
    assign out_w[k]           = out_q;
    assign out_prev_w[k]      = out_prev_q;
    assign count_o[k]         = cnt_q;
    assign latch_o[k]         = latch_q;
    assign running_o[k]       = run_q;
    assign tc_o[k]            = tc_q;
    assign gate_evt_o[k]      = evt_q;
    assign int_out_o[k]       = out_q;
    assign src_exp_o[k]       = sexp_q;
    assign src_exp_oe_n_o[k]  = sexp_oe_n_q;
    assign gate_exp_o[k]      = gexp_q;
    assign gate_exp_oe_n_o[k] = gexp_oe_n_q;
  end

  // ========================================================
  // First counter output routing
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ai_samp_clk_o  <= 1'b0;
      ai_start_o     <= 1'b0;
      ai_conv_clk_o  <= 1'b0;
      trig_line_o    <= '0;
      ctr_out_pin_o  <= 1'b0;
      ctr_out_oe_n_o <= `GPC_OE_N_RST;
    end else begin
      ai_samp_clk_o  <= route_i.ai_samp_en & out_w[0];
      ai_start_o     <= route_i.ai_start_en & out_w[0];
      ai_conv_clk_o  <= route_i.ai_conv_en & out_w[0];
      trig_line_o    <= route_i.trig_en & {`GPC_TRIG_LINES{out_w[0]}};
      ctr_out_pin_o  <= out_w[0];
      ctr_out_oe_n_o <= ~route_i.out_pin_en;
    end
  end

endmodule // gpc_top

// >>> gpc_top_monitor.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checker for the dual counter block
module gpc_top_monitor
  import gpc_pkg::*;
(
  input wire logic           sys_clk_i,       // Clock
  input wire logic           srst_i,          // Sync reset
  input wire gpc_cfg_t [1:0] cfg_i,           // Setup
  input wire logic [1:0]     arm_i,           // Start
  input wire logic [1:0]     disarm_i,        // Stop
  input wire gpc_route_t     route_i,         // Routing
  input wire logic [1:0]     running_o,       // Armed
  input wire logic [1:0]     tc_o,            // Terminal count
  input wire logic [1:0]     gate_evt_o,      // Gate edge
  input wire logic [1:0]     int_out_o,       // Outputs
  input wire logic [1:0]     src_exp_oe_n_o,  // Source oe
  input wire logic [1:0]     gate_exp_oe_n_o, // Gate oe
  input wire logic           ai_samp_clk_o,   // Sample clk
  input wire logic           ai_start_o,      // Start trig
  input wire logic           ai_conv_clk_o,   // Conv clk
  input wire logic [6:0]     trig_line_o,     // Trig lines
  input wire logic           ctr_out_pin_o,   // Out pin
  input wire logic           ctr_out_oe_n_o   // Out pin oe
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // ========================================================
  // Export pins undriven out of reset; first source export undriven while off
  property p_oe_idle;
    $fell(srst_i) |-> &{src_exp_oe_n_o, gate_exp_oe_n_o, ctr_out_oe_n_o};
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("export pin driven after reset");
  property p_src_oe;
    !cfg_i[0].src_exp_en ##1 !cfg_i[0].src_exp_en |-> src_exp_oe_n_o[0];
  endproperty
  a_src_oe: assert property (p_src_oe)
    else $error("source export driven while off");

  // ========================================================
  // Routing follows the first output one cycle later
  property p_route_ai;
    !$past(srst_i) |->
      ai_samp_clk_o == $past(route_i.ai_samp_en & int_out_o[0]) &&
      ai_start_o == $past(route_i.ai_start_en & int_out_o[0]) &&
      ai_conv_clk_o == $past(route_i.ai_conv_en & int_out_o[0]);
  endproperty
  a_route_ai: assert property (p_route_ai)
    else $error("analog routing mismatch");
  property p_route_trig;
    !$past(srst_i) |->
      trig_line_o == $past(route_i.trig_en & {7{int_out_o[0]}});
  endproperty
  a_route_trig: assert property (p_route_trig)
    else $error("trigger routing mismatch");
  property p_route_pin;
    !$past(srst_i) && $past(route_i.out_pin_en) |->
      ctr_out_pin_o == $past(int_out_o[0]) && !ctr_out_oe_n_o;
  endproperty
  a_route_pin: assert property (p_route_pin)
    else $error("pin routing mismatch");

  // ========================================================
  // Output behaviour on terminal count; arm loads excluded, and stops and gate events from the toggle check
  property p_toggle;
    tc_o[0] && (cfg_i[0].out_toggle || cfg_i[0].mode == MODE_PULSE) &&
    !$past(arm_i[0]) && !$past(disarm_i[0]) && !gate_evt_o[0] &&
    $stable(cfg_i[0]) |=> int_out_o[0] != $past(int_out_o[0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("no toggle on terminal count");
  property p_pulse_tc;
    tc_o[0] && !cfg_i[0].out_toggle && cfg_i[0].mode == MODE_EDGE &&
    !$past(arm_i[0]) && $stable(cfg_i[0]) |=>
      int_out_o[0] != cfg_i[0].out_inv;
  endproperty
  a_pulse_tc: assert property (p_pulse_tc)
    else $error("no pulse on terminal count");
  property p_tc_once;
    tc_o[0] |=> !tc_o[0];
  endproperty
  a_tc_once: assert property (p_tc_once)
    else $error("terminal count too long");

  // ========================================================
  // Arm and disarm reach the running flag in two cycles
  property p_arm;
    arm_i[0] && !disarm_i[0] |-> ##2 running_o[0];
  endproperty
  a_arm: assert property (p_arm)
    else $error("not running after arm");
  property p_disarm;
    disarm_i[1] |-> ##2 !running_o[1];
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("running after disarm");
endmodule // gpc_top_monitor

bind gpc_top gpc_top_monitor u_mon (
  .sys_clk_i, .srst_i, .cfg_i, .arm_i, .disarm_i, .route_i, .running_o,
  .tc_o, .gate_evt_o, .int_out_o, .src_exp_oe_n_o, .gate_exp_oe_n_o,
  .ai_samp_clk_o, .ai_start_o, .ai_conv_clk_o, .trig_line_o,
  .ctr_out_pin_o, .ctr_out_oe_n_o
);

// >>> test_dual_gp_counter.sv
`timescale 1ns/1ps

module test_dual_gp_counter;
  import gpc_pkg::*;
  localparam int CW = 8;  // Short counts make rollover quick to reach
  logic                  sys_clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  gpc_cfg_t [1:0]        cfg_i;
  gpc_route_t            route_i;
  logic [1:0][CW-1:0]    low_ticks_i, high_ticks_i, pulse_cnt_i;
  logic [1:0][CW-1:0]    count_o, latch_o;
  logic [1:0]            arm_i, disarm_i, src_pin_i, gate_pin_i, dir_pin_i;
  logic [1:0]            running_o, tc_o, gate_evt_o, int_out_o, src_exp_o;
  logic [1:0]            src_exp_oe_n_o, gate_exp_o, gate_exp_oe_n_o;
  logic                  acmp_evt_i, ai_samp_clk_o, ai_start_o;
  logic                  ai_conv_clk_o, ctr_out_pin_o, ctr_out_oe_n_o;
  logic [6:0]            trig_line_o;
  logic                  out_q = 1'b0, pin_q = 1'b0;
  int                    bad_count = 0, checks_done = 0;
  int                    tc_hits = 0, out_rises = 0, pin_rises = 0;

  gpc_top #(.CW(CW)) DUT (
    .sys_clk_i, .srst_i, .cfg_i, .low_ticks_i, .high_ticks_i, .pulse_cnt_i,
    .arm_i, .disarm_i, .src_pin_i, .gate_pin_i, .dir_pin_i, .acmp_evt_i,
    .route_i, .count_o, .latch_o, .running_o, .tc_o, .gate_evt_o,
    .int_out_o, .src_exp_o, .src_exp_oe_n_o, .gate_exp_o, .gate_exp_oe_n_o,
    .ai_samp_clk_o, .ai_start_o, .ai_conv_clk_o, .trig_line_o,
    .ctr_out_pin_o, .ctr_out_oe_n_o
  );
  gpc_pin_model u_pins (
    .sys_clk_i, .src_pin_o(src_pin_i), .gate_pin_o(gate_pin_i),
    .dir_pin_o(dir_pin_i)
  );

  // ========================================================
  // Clock, event tallies and shared tasks
  always #10 sys_clk_i = ~sys_clk_i;
  // Tallies read pre-edge values, so they never race the design
  always @(posedge sys_clk_i) begin
    if (tc_o[0]) tc_hits++;
    if (int_out_o[0] && !out_q) out_rises++;
    if (ctr_out_pin_o && !pin_q) pin_rises++;
    out_q = int_out_o[0];
    pin_q = ctr_out_pin_o;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic cmp_val(input logic [CW-1:0] got, input logic [CW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({7'h00, got}, {7'h00, exp});
  endtask
  task automatic arm(input int k);
    arm_i[k] = 1'b1;
    step(1);
    arm_i[k] = 1'b0;
    step(2);
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_reset();
    cmp_val({src_exp_oe_n_o, gate_exp_oe_n_o, ctr_out_oe_n_o, running_o,
             1'b0}, 8'hF8); // Idle pins
    cmp_val(count_o[0], 8'h00); // Cleared count
  endtask
  // Both edges and directions, pin direction, rollover
  task automatic t_edge();
    gpc_cfg_t       c;
    logic [CW-1:0]  pre;
    logic [3:0]     fall = 4'b1010, ext = 4'b0110, up = 4'b0101;
    int             h0;
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.src_fall = fall[i];
      c.dir_ext = ext[i];
      c.dir_up = up[i] ^ ext[i];  // Pin direction must override this
      c.out_inv = i[0];
      c.src_exp_en = 1'b1;
      cfg_i[0] = c;
      u_pins.set_ctl(1'b0, 0, up[i]);
      pre = up[i] ? 8'hFD : 8'h02;
      low_ticks_i[0] = pre;
      arm(0);
      h0 = tc_hits;
      cmp_val(count_o[0], pre); // Preload
      u_pins.set_src(0, 1'b1);
      cmp_val(count_o[0], fall[i] ? pre : (up[i] ? pre + 8'h01
              : pre - 8'h01)); // Rising edge
      u_pins.set_src(0, 1'b0);
      u_pins.pulse_src(0, 2);
      cmp_val(count_o[0], up[i] ? 8'h00 : 8'hFF); // Wrap
      cmp_val(CW'(tc_hits - h0), 8'h01); // One rollover
      cmp_bit(src_exp_oe_n_o[0], 1'b0); // Export on
    end
  endtask
  // Pause on the second counter, with gate export
  task automatic t_pause();
    gpc_cfg_t c;
    c = '0;
    c.pause_en = 1'b1;
    c.dir_up = 1'b1;
    c.latch_en = 1'b1;
    c.gate_exp_en = 1'b1;
    cfg_i[1] = c;
    low_ticks_i[1] = 8'h10;
    u_pins.set_ctl(1'b1, 1, 1'b0);
    arm(1);
    u_pins.pulse_src(1, 2);
    cmp_val(count_o[1], 8'h10); // Held
    cmp_bit(gate_exp_oe_n_o[1], 1'b0); // Export on
    u_pins.set_ctl(1'b1, 1, 1'b1);
    cmp_bit(gate_exp_o[1], 1'b1); // Gate level
    u_pins.pulse_src(1, 2);
    cmp_val(count_o[1], 8'h12); // Resumed
    cmp_val(latch_o[1], 8'h10); // Latched at gate edge
  endtask
  // Finite fast-timebase train started by a gate edge
  task automatic t_pulse();
    gpc_cfg_t c;
    int       r0, p0, n;
    c = '0;
    c.src_sel = SRC_FAST;
    c.mode = MODE_PULSE;
    c.start_en = 1'b1;
    c.out_toggle = 1'b1;
    cfg_i[0] = c;
    low_ticks_i[0] = 8'h02;
    high_ticks_i[0] = 8'h01;
    pulse_cnt_i[0] = 8'h03;
    route_i = '1;
    u_pins.set_ctl(1'b1, 0, 1'b0);
    arm(0);
    r0 = out_rises;
    p0 = pin_rises;
    step(30);
    cmp_val(CW'(out_rises - r0), 8'h00); // Waits for start
    u_pins.set_ctl(1'b1, 0, 1'b1);
    n = 0;
    while (running_o[0] !== 1'b0 && n < 400) begin
      step(1);
      n++;
    end
    step(3);
    cmp_val(CW'(out_rises - r0), 8'h03); // Exact count
    cmp_val(CW'(pin_rises - p0), 8'h03); // Pin copy
  endtask
  // Continuous train paused by its gate, cascaded into counter 1
  task automatic t_cont();
    gpc_cfg_t c;
    int       r0;
    c = '0;
    c.src_sel = SRC_FAST;
    c.mode = MODE_PULSE;
    c.continuous = 1'b1;
    c.pause_en = 1'b1;
    c.out_toggle = 1'b1;
    cfg_i[0] = c;
    low_ticks_i[0] = 8'h01;
    c = '0;
    c.src_sel = SRC_FAST;
    c.gate_sel = GATE_OTHER;
    c.pause_en = 1'b1;
    c.dir_up = 1'b1;
    cfg_i[1] = c;
    low_ticks_i[1] = 8'h00;
    u_pins.set_ctl(1'b1, 0, 1'b0);
    arm(0);
    arm(1);
    r0 = out_rises;
    step(40);
    cmp_val(CW'(out_rises - r0), 8'h00); // Paused
    cmp_val(count_o[1], 8'h00); // Gate low
    u_pins.set_ctl(1'b1, 0, 1'b1);
    step(40);
    cmp_bit(out_rises - r0 > 3, 1'b1); // Runs on
    cmp_bit(count_o[1] != 8'h00, 1'b1); // Cascade
    disarm_i = 2'b11;
    step(1);
    disarm_i = 2'b00;
    step(2);
    cmp_val({6'h00, running_o}, 8'h00); // Stopped
  endtask
  // Slow timebase gives one tick per 500 clocks
  task automatic t_slow();
    gpc_cfg_t c;
    c = '0;
    c.src_sel = SRC_SLOW;
    c.dir_up = 1'b1;
    cfg_i[1] = c;
    arm(1);
    step(1100);
    cmp_bit(count_o[1] >= 8'h02 && count_o[1] <= 8'h03, 1'b1);
  endtask

  // ========================================================
  // Main sequence; analog compare input is left idle
  initial begin
    {cfg_i, route_i, arm_i, disarm_i, acmp_evt_i} = '0;
    {low_ticks_i, high_ticks_i, pulse_cnt_i} = '0;
    step(6);
    srst_i = 1'b0;
    step(4);
    t_reset();
    t_edge();
    t_pause();
    t_pulse();
    t_cont();
    t_slow();
    conclude();
  end
  // Watchdog: the sequence needs well under 5000 clocks
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    conclude();
  end
endmodule // test_dual_gp_counter
